//--- sequencer_pkg.sv
`default_nettype none
package sequencer_pkg;
  // Clock rate and periods
  localparam int unsigned CLOCK_HZ = 10_000_000;
  localparam int unsigned DEBOUNCE_MS = 32;
  localparam int unsigned BLANK_MS = 512;
  localparam int unsigned POWER_DOWN_MS = 1024;
  localparam int unsigned LOCKOUT_MS = 256;
  localparam int unsigned CYCLES_PER_MS = CLOCK_HZ / 1000;
  localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_MS * CYCLES_PER_MS;
  localparam int unsigned BLANK_CYCLES = BLANK_MS * CYCLES_PER_MS;
  localparam int unsigned POWER_DOWN_CYCLES = POWER_DOWN_MS * CYCLES_PER_MS;
  localparam int unsigned LOCKOUT_CYCLES = LOCKOUT_MS * CYCLES_PER_MS;
  // Counter and extension widths
  localparam int unsigned COUNT_WIDTH = 32;
  localparam int unsigned EXTEND_WIDTH = 24;
  // Sequencer states
  typedef enum logic [2:0] {
    IDLE_STATE = 3'h0,
    ON_DEBOUNCE_STATE = 3'h1,
    BLANK_STATE = 3'h2,
    RELEASE_STATE = 3'h3,
    RUN_STATE = 3'h4,
    OFF_DEBOUNCE_STATE = 3'h5,
    POWER_DOWN_STATE = 3'h6,
    LOCKOUT_STATE = 3'h7
  } seq_state_type;
endpackage
`default_nettype wire

//--- input_sync.sv
`default_nettype none
// Two-flop synchroniser for one pin, resets to a given level
module input_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output logic sync_o
);
  logic stage_reg;
  logic stage_next;
  logic sync_reg;
  logic sync_next;

  // Next values
  always_comb begin
    stage_next = pin_i;
    sync_next = stage_reg;
  end

  // Register both stages
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      stage_reg <= RESET_LEVEL;
      sync_reg <= RESET_LEVEL;
    end else begin
      stage_reg <= stage_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_o = sync_reg;
endmodule
`default_nettype wire

//--- pushbutton_power_sequencer.sv
// Behaviour
// - Enable only after continuous low plus extension
// - No extension means default debounce alone
// - Shutdown starts after low plus off extension
// - Valid off press drives shutdown request low
// - Blanking ignores kill and pushbutton
// - Kill low at blank end releases enable
// - Power-down delay expiry releases enable
// - Kill low during delay releases at once
// - Kill low in run releases enable quickly
// - Enable polarity selected by variant
// - Lockout ignores pushbutton after release
// - Pushbutton high restarts debounce timer
// - Release debounced before accepting new press
// - Enable deasserted after reset
`default_nettype none
module pushbutton_power_sequencer
  import sequencer_pkg::*;
#(
  parameter logic ENABLE_ACTIVE_HIGH = 1'b1,
  parameter int unsigned BLANK_COUNT = BLANK_CYCLES,
  parameter int unsigned POWER_DOWN_COUNT = POWER_DOWN_CYCLES,
  parameter int unsigned LOCKOUT_COUNT = LOCKOUT_CYCLES,
  parameter int unsigned DEBOUNCE_COUNT = DEBOUNCE_CYCLES
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Pins
  input wire logic pushbutton_n_i,
  input wire logic kill_n_i,
  // Static extension configuration in clock ticks
  input wire logic [sequencer_pkg::EXTEND_WIDTH-1:0] turn_on_extend_i,
  input wire logic [sequencer_pkg::EXTEND_WIDTH-1:0] turn_off_extend_i,
  // Outputs
  output logic power_enable_o,
  output logic shutdown_request_n_o,
  output logic shutdown_request_oe_o
);
  import sequencer_pkg::*;

  logic pushbutton_n;
  logic kill_n;
  seq_state_type state_reg;
  seq_state_type state_next;
  logic [COUNT_WIDTH-1:0] count_reg;
  logic [COUNT_WIDTH-1:0] count_next;
  logic enabled_reg;
  logic enabled_next;
  logic request_reg;
  logic request_next;
  logic lockout_done_reg;
  logic lockout_done_next;
  logic en_pin_reg;
  logic en_pin_next;
  logic [COUNT_WIDTH-1:0] on_target;
  logic [COUNT_WIDTH-1:0] off_target;

  // Synchronise the pins, both idle high
  input_sync #(.RESET_LEVEL(1'b1)) pb_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .pin_i(pushbutton_n_i),
    .sync_o(pushbutton_n)
  );
  input_sync #(.RESET_LEVEL(1'b1)) kill_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .pin_i(kill_n_i),
    .sync_o(kill_n)
  );

  // Debounce targets: default period plus extension
  assign on_target = COUNT_WIDTH'(DEBOUNCE_COUNT)
    + COUNT_WIDTH'(turn_on_extend_i);
  assign off_target = COUNT_WIDTH'(DEBOUNCE_COUNT)
    + COUNT_WIDTH'(turn_off_extend_i);

  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    count_next = count_reg + 32'h0000_0001;
    enabled_next = enabled_reg;
    request_next = request_reg;
    lockout_done_next = lockout_done_reg;
    unique case (state_reg)
      IDLE_STATE: begin
        count_next = '0;
        if (!pushbutton_n) begin
          state_next = ON_DEBOUNCE_STATE;
          count_next = 32'h0000_0001;
        end
      end
      ON_DEBOUNCE_STATE: begin
        if (pushbutton_n) begin
          state_next = IDLE_STATE;
          count_next = '0;
        end else if (count_reg >= on_target) begin
          state_next = BLANK_STATE;
          enabled_next = 1'b1;
          count_next = '0;
        end
      end
      BLANK_STATE: begin
        // Pushbutton not looked at here, kill only at the end of blanking
        if (count_reg >= COUNT_WIDTH'(BLANK_COUNT) - 32'h0000_0001) begin
          count_next = '0;
          if (!kill_n) begin
            enabled_next = 1'b0;
            state_next = LOCKOUT_STATE;
            lockout_done_next = 1'b0;
          end else begin
            state_next = RELEASE_STATE;
          end
        end
      end
      RELEASE_STATE: begin
        if (!kill_n) begin
          enabled_next = 1'b0;
          state_next = LOCKOUT_STATE;
          lockout_done_next = 1'b0;
          count_next = '0;
        end else if (!pushbutton_n) begin
          count_next = '0;
        end else if (count_reg >= COUNT_WIDTH'(DEBOUNCE_COUNT)) begin
          state_next = enabled_reg ? RUN_STATE : IDLE_STATE;
          count_next = '0;
        end
      end
      RUN_STATE: begin
        count_next = '0;
        if (!kill_n) begin
          enabled_next = 1'b0;
          state_next = LOCKOUT_STATE;
          lockout_done_next = 1'b0;
        end else if (!pushbutton_n) begin
          state_next = OFF_DEBOUNCE_STATE;
          count_next = 32'h0000_0001;
        end
      end
      OFF_DEBOUNCE_STATE: begin
        if (!kill_n) begin
          enabled_next = 1'b0;
          state_next = LOCKOUT_STATE;
          lockout_done_next = 1'b0;
          count_next = '0;
        end else if (pushbutton_n) begin
          state_next = RUN_STATE;
          count_next = '0;
        end else if (count_reg >= off_target) begin
          state_next = POWER_DOWN_STATE;
          request_next = 1'b1;
          count_next = '0;
        end
      end
      POWER_DOWN_STATE: begin
        if (!kill_n || count_reg >=
            COUNT_WIDTH'(POWER_DOWN_COUNT) - 32'h0000_0001) begin
          enabled_next = 1'b0;
          request_next = 1'b0;
          lockout_done_next = 1'b0;
          state_next = LOCKOUT_STATE;
          count_next = '0;
        end
      end
      LOCKOUT_STATE: begin
        // Lockout first, then debounce the release of the button
        if (!lockout_done_reg) begin
          if (count_reg >= COUNT_WIDTH'(LOCKOUT_COUNT) - 32'h0000_0001) begin
            lockout_done_next = 1'b1;
            count_next = '0;
          end
        end else if (!pushbutton_n) begin
          count_next = '0;
        end else if (count_reg >= COUNT_WIDTH'(DEBOUNCE_COUNT)) begin
          state_next = IDLE_STATE;
          count_next = '0;
        end
      end
    endcase
  end

  // Sequencer registers, enable off after reset
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_reg <= IDLE_STATE;
      count_reg <= '0;
      enabled_reg <= 1'b0;
      request_reg <= 1'b0;
      lockout_done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      enabled_reg <= enabled_next;
      request_reg <= request_next;
      lockout_done_reg <= lockout_done_next;
    end
  end

  // Enable pin level for the selected variant
  always_comb begin
    en_pin_next = enabled_next ~^ ENABLE_ACTIVE_HIGH;
  end

  // Enable pin register, released level after reset
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      en_pin_reg <= ~ENABLE_ACTIVE_HIGH;
    end else begin
      en_pin_reg <= en_pin_next;
    end
  end

  // Open-drain request: output level low, enabled while asserted
  assign power_enable_o = en_pin_reg;
  assign shutdown_request_n_o = 1'b0;
  assign shutdown_request_oe_o = request_reg;
endmodule
`default_nettype wire

//--- sequencer_props.sv
`default_nettype none
module sequencer_props
  import sequencer_pkg::*;
#(
  parameter logic ENABLE_ACTIVE_HIGH = 1'b1,
  parameter int unsigned BLANK_COUNT = 50,
  parameter int unsigned POWER_DOWN_COUNT = 100,
  parameter int unsigned LOCKOUT_COUNT = 30,
  parameter int unsigned DEBOUNCE_COUNT = 10
) (
  // Clock, reset and pins
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic pushbutton_n_i,
  input wire logic kill_n_i,
  input wire logic [sequencer_pkg::EXTEND_WIDTH-1:0] turn_on_extend_i,
  input wire logic [sequencer_pkg::EXTEND_WIDTH-1:0] turn_off_extend_i,
  // Watched outputs
  input wire logic power_enable_o,
  input wire logic shutdown_request_n_o,
  input wire logic shutdown_request_oe_o
);
  logic on;
  int unsigned low_n, on_n, rq_n, off_n;
  assign on = power_enable_o == ENABLE_ACTIVE_HIGH;
  // Run lengths of button low, enable on, request on, enable off
  always_ff @(posedge clock_i) begin
    low_n <= (rst_i || pushbutton_n_i) ? 0 : low_n + 1;
    on_n <= (rst_i || !on) ? 0 : on_n + 1;
    rq_n <= (rst_i || !shutdown_request_oe_o) ? 0 : rq_n + 1;
    off_n <= rst_i ? 1000 : (on ? 0 : off_n + 1);
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  reset_off_a: assert property (disable iff (1'b0) rst_i |=> !on)
    else $error("enable on after reset");
  // Pin low run three edges back, past the two-flop synchroniser
  on_debounce_a: assert property ($rose(on) |->
    $past(low_n, 3) >= DEBOUNCE_COUNT + turn_on_extend_i)
    else $error("early enable");
  off_debounce_a: assert property ($rose(shutdown_request_oe_o) |->
    $past(low_n, 3) >= DEBOUNCE_COUNT + turn_off_extend_i)
    else $error("early request");
  request_level_a: assert property (shutdown_request_n_o == 1'b0)
    else $error("request pin driven high");
  kill_power_down_a: assert property (shutdown_request_oe_o && !kill_n_i
    |-> ##[1:5] !on) else $error("kill ignored in power down");
  request_needs_on_a: assert property (shutdown_request_oe_o |-> on)
    else $error("request while off");
  request_with_en_a: assert property ($fell(on) |->
    !shutdown_request_oe_o) else $error("request outlives enable");
  blank_hold_a: assert property ($fell(on) |-> on_n >= BLANK_COUNT)
    else $error("enable dropped in blanking");
  power_down_a: assert property (shutdown_request_oe_o |->
    rq_n <= POWER_DOWN_COUNT) else $error("power down too long");
  kill_run_a: assert property (on && on_n > BLANK_COUNT + 4 && !kill_n_i
    |-> ##[1:5] !on) else $error("kill not obeyed");
  lockout_a: assert property ($rose(on) |-> off_n >= LOCKOUT_COUNT)
    else $error("restart in lockout");
endmodule
bind pushbutton_power_sequencer sequencer_props #(
  .ENABLE_ACTIVE_HIGH(ENABLE_ACTIVE_HIGH), .BLANK_COUNT(BLANK_COUNT),
  .POWER_DOWN_COUNT(POWER_DOWN_COUNT), .LOCKOUT_COUNT(LOCKOUT_COUNT),
  .DEBOUNCE_COUNT(DEBOUNCE_COUNT)) u_sequencer_props (
  .clock_i(clock_i), .rst_i(rst_i), .pushbutton_n_i(pushbutton_n_i),
  .kill_n_i(kill_n_i), .turn_on_extend_i(turn_on_extend_i),
  .turn_off_extend_i(turn_off_extend_i), .power_enable_o(power_enable_o),
  .shutdown_request_n_o(shutdown_request_n_o),
  .shutdown_request_oe_o(shutdown_request_oe_o));
`default_nettype wire

//--- uproc_model.sv
`default_nettype none
module uproc_model (
  // Clock and device side
  input wire logic clock_i,
  input wire logic enable_on_i,
  input wire logic int_n_i,
  input wire logic [1:0] mode_i,
  // Kill line
  output logic kill_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned up_n, ack_n;
  // Time powered and time since the request
  always @(posedge clock_i) begin
    up_n <= enable_on_i ? up_n + 1 : 0;
    ack_n <= (enable_on_i && !int_n_i) ? ack_n + 1 : 0;
  end
  // Unpowered or booting holds kill low; mode 0 never boots
  assign kill_n_o = enable_on_i && mode_i != 2'h0 && up_n >= 10
    && !(mode_i == 2'h1 && ack_n >= 20)
    && !(mode_i == 2'h3 && !int_n_i);
endmodule
`default_nettype wire

//--- pushbutton_power_sequencer_tb.sv
`default_nettype none
module pushbutton_power_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned DB = 10, BL = 50, PD = 100, LO = 30;
  typedef struct {
    int unsigned on_hold, off_hold, lo, hi;
    logic [1:0] mode;
  } row_type;
  logic clock_i = 0, rst_i = 1, button_n = 1;
  logic [1:0] mode = 2'h0;
  logic [23:0] on_ext = 24'h5;
  logic kill_n, en, en_low, oe, req_n, int_n;
  int unsigned errors = 0, n_compared = 0, en_cycles = 0, rq_cycles = 0;
  int unsigned pol_bad = 0, en_base, rq_base, span;
  row_type rows[5] = '{'{14, 0, 0, 0, 2'h1}, '{20, 0, BL, BL + 4, 2'h0},
    '{20, 20, 20, 28, 2'h1}, '{20, 20, PD - 2, PD + 2, 2'h2},
    '{20, 20, 1, 6, 2'h3}};
  always #50 clock_i = ~clock_i;
  assign int_n = oe ? req_n : 1'b1;
  pushbutton_power_sequencer #(.BLANK_COUNT(BL), .POWER_DOWN_COUNT(PD),
    .LOCKOUT_COUNT(LO), .DEBOUNCE_COUNT(DB)) u_pushbutton_power_sequencer (
    .clock_i(clock_i), .rst_i(rst_i), .pushbutton_n_i(button_n),
    .kill_n_i(kill_n), .turn_on_extend_i(on_ext), .turn_off_extend_i(24'h3),
    .power_enable_o(en), .shutdown_request_n_o(req_n),
    .shutdown_request_oe_o(oe));
  pushbutton_power_sequencer #(.ENABLE_ACTIVE_HIGH(1'b0), .BLANK_COUNT(BL),
    .POWER_DOWN_COUNT(PD), .LOCKOUT_COUNT(LO), .DEBOUNCE_COUNT(DB))
    u_pushbutton_power_sequencer_low (.clock_i(clock_i), .rst_i(rst_i),
    .pushbutton_n_i(button_n), .kill_n_i(kill_n),
    .turn_on_extend_i(on_ext), .turn_off_extend_i(24'h3),
    .power_enable_o(en_low), .shutdown_request_n_o(),
    .shutdown_request_oe_o());
  uproc_model u_uproc_model (.clock_i(clock_i), .enable_on_i(en),
    .int_n_i(int_n), .mode_i(mode), .kill_n_o(kill_n));
  // Tally on time, request time and polarity slips outside reset
  always @(posedge clock_i) begin
    if (!rst_i) begin
      en_cycles <= en_cycles + en;
      rq_cycles <= rq_cycles + oe;
      pol_bad <= pol_bad + (en_low !== ~en);
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t got %0h want %0h", $time, seen, exp);
    end
  endtask
  task automatic step(input int unsigned n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic press(input int unsigned n);
    button_n = 0;
    step(n);
    button_n = 1;
    step(1);
  endtask
  task automatic report_and_stop;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Main sequence: reset, table rows, then hand cases
  initial begin
    step(16);
    check(en, 1'b0);
    check(oe, 1'b0);
    rst_i = 0;
    step(4);
    check(en | oe, 1'b0);
    $display("reset done");
    foreach (rows[i]) begin
      mode = rows[i].mode;
      en_base = en_cycles;
      rq_base = rq_cycles;
      press(rows[i].on_hold);
      step(BL + 2 * DB);
      if (rows[i].off_hold > 0)
        press(rows[i].off_hold);
      step(PD + LO + 2 * DB + 20);
      span = rows[i].off_hold ? rq_cycles - rq_base : en_cycles - en_base;
      check(span inside
        {[rows[i].lo : rows[i].hi]}, 1);
      check(en | oe, 1'b0);
      $display("row %0d done", i);
    end
    mode = 2'h1;
    en_base = en_cycles;
    press(10);
    press(10);
    step(30);
    check(en_cycles - en_base, 0);
    $display("bounce done");
    mode = 2'h0;
    en_base = en_cycles;
    press(BL + LO + 60);
    step(LO + 2 * DB);
    check(en_cycles - en_base inside {[BL : BL + 4]}, 1);
    $display("held press done");
    // No extension: a press of the default debounce alone turns on
    on_ext = 24'h0;
    en_base = en_cycles;
    press(DB + 2);
    step(BL + LO + 2 * DB + 20);
    check(en_cycles - en_base inside {[BL : BL + 4]}, 1);
    $display("no extension done");
    // Reset while powered drops enable on both variants
    mode = 2'h2;
    press(20);
    step(BL + 2 * DB);
    check(en, 1'b1);
    rst_i = 1;
    step(4);
    check(en, 1'b0);
    check(en_low, 1'b1);
    rst_i = 0;
    step(4);
    check(en | oe, 1'b0);
    check(pol_bad, 0);
    $display("mid reset done");
    report_and_stop;
  end
  // Watchdog
  initial begin
    step(20000);
    errors++;
    report_and_stop;
  end
endmodule
`default_nettype wire
